/* iepm_pkg.sv */
package iepm_pkg;
	// Register byte addresses on the APB
	localparam logic [7:0] IEPM_OFS_IE     = 8'h00; // Interrupt enable mask
	localparam logic [7:0] IEPM_OFS_PWR    = 8'h04; // Power mode control
	localparam logic [7:0] IEPM_OFS_T2CTL  = 8'h08; // Timer 2 flags and mode
	localparam logic [7:0] IEPM_OFS_STAT   = 8'h0C; // Request status
	// Interrupt enable mask field positions
	localparam int IEPM_IE_GLOBAL = 7;
	localparam int IEPM_IE_T2     = 5;
	localparam int IEPM_IE_SER    = 4;
	localparam int IEPM_IE_T1     = 3;
	localparam int IEPM_IE_X1     = 2;
	localparam int IEPM_IE_T0     = 1;
	localparam int IEPM_IE_X0     = 0;
	localparam logic [7:0] IEPM_IE_RESET   = 8'h00;
	localparam logic [7:0] IEPM_IE_IMPL    = 8'hBF; // Bit 6 not stored
	// Power control fields
	localparam int IEPM_PWR_IDLE  = 0;
	localparam int IEPM_PWR_DOWN  = 1;
	localparam int IEPM_PWR_EXTPM = 2;
	// Timer 2 control fields
	localparam int IEPM_T2_OVF    = 7;
	localparam int IEPM_T2_EXT    = 6;
	localparam int IEPM_T2_TRIGEN = 3;
	localparam int IEPM_T2_UPDN   = 1;
	localparam int IEPM_T2_CLKOUT = 0;
	localparam logic [7:0] IEPM_T2_RESET = 8'h00;
	// Machine cycle: twelve oscillator periods at the core clock
	localparam int          IEPM_MC_LEN  = 12;
	localparam logic [3:0]  IEPM_PH_ST2P2 = 4'h3;
	localparam logic [3:0]  IEPM_PH_ST5P2 = 4'h9;
	// Reset-out-of-idle window: two machine cycles
	localparam int IEPM_RST_WIN_MC = 2;
	typedef enum logic [2:0] {
		IEPM_RUN  = 3'b001,
		IEPM_IDLE = 3'b010,
		IEPM_DOWN = 3'b100
	} iepm_mode_e;
endpackage

/* iepm_src_if.sv */
interface iepm_src_if;
	import iepm_pkg::*;
	logic [5:0] raw;     // Raw requests: x0,t0,x1,t1,ser,t2
	logic [7:0] mask;    // Interrupt enable mask
	logic [5:0] gated;   // Enabled requests
	logic       any;     // Any enabled request
	modport gate (input raw, input mask, output gated, output any);
	modport ctrl (output raw, output mask, input gated, input any);
endinterface

/* iepm_gate.sv */
module iepm_gate
	import iepm_pkg::*;
(
	iepm_src_if.gate s
);
	// Per-source enable, then global enable over all
	wire glb = s.mask[IEPM_IE_GLOBAL];
	wire [5:0] per = {s.mask[IEPM_IE_T2], s.mask[IEPM_IE_SER],
		s.mask[IEPM_IE_T1], s.mask[IEPM_IE_X1], s.mask[IEPM_IE_T0],
		s.mask[IEPM_IE_X0]};
	assign s.gated = s.raw & per & {6{glb}};
	assign s.any   = |s.gated;
endmodule

/* iepm_top.sv */
// Decided for this implementation: the APB slave port and the register addresses.
module iepm_top
	import iepm_pkg::*;
(
	input  wire logic        CLK,
	input  wire logic        SRST,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic        OUTSIDE_IRQ_LINE0_N,
	input  wire logic        OUTSIDE_IRQ_LINE1_N,
	input  wire logic        TIMER0_ROLLOVER,
	input  wire logic        TIMER1_ROLLOVER,
	input  wire logic        TIMER2_ROLLOVER,
	input  wire logic        SERIAL_IRQ,
	input  wire logic        TIMER2_TRIGGER_PIN,
	input  wire logic        RESET_PIN,
	output logic      [5:0]  IRQ_REQ,
	output logic             CPU_RUN,
	output logic             OSC_RUN,
	output logic             RAM_WR_BLOCK,
	output logic             ADDR_LATCH_STROBE,
	output logic             PROGRAM_STORE_STROBE,
	output logic             PORT0_FLOAT,
	output logic             PORT2_ADDR_SEL
);
	////////////////////////////////////////////////////////////////////
	// APB decode
	wire wr_en  = PSEL & PENABLE & PWRITE;
	wire hit_ie = PADDR == IEPM_OFS_IE;
	wire hit_pw = PADDR == IEPM_OFS_PWR;
	wire hit_t2 = PADDR == IEPM_OFS_T2CTL;
	wire hit_st = PADDR == IEPM_OFS_STAT;
	wire mapped = hit_ie | hit_pw | hit_t2 | hit_st;
	// Single-cycle access phase; unmapped addresses get an error
	assign PREADY  = 1'b1;
	assign PSLVERR = PSEL & PENABLE & ~mapped;

	logic [7:0] ie_reg, ie_next;
	logic [7:0] t2_reg, t2_next;
	logic       extpm_reg;
	iepm_mode_e mode_reg, mode_next;
	logic [3:0] phase_reg;
	logic [1:0] rwin_reg;
	logic       trig_q_reg;
	logic [1:0] t01_pend_reg;
	logic [1:0] t01_hold_reg;
	logic [5:0] irq_reg;

	////////////////////////////////////////////////////////////////////
	// Machine cycle phase counter; state phases as enable pulses
	wire mc_end = phase_reg == 4'(IEPM_MC_LEN - 1);
	wire at_s2  = phase_reg == IEPM_PH_ST2P2;
	wire at_s5  = phase_reg == IEPM_PH_ST5P2;
	always_ff @(posedge CLK) begin
		if (SRST | mc_end)
			phase_reg <= 4'h0;
		else if (mode_reg != IEPM_DOWN)
			phase_reg <= phase_reg + 4'h1; // Oscillator frozen in down
	end

	////////////////////////////////////////////////////////////////////
	// Timer 0/1 flags latch at state5 phase2, shown from the next cycle
	always_ff @(posedge CLK) begin
		if (SRST) begin
			t01_pend_reg <= 2'b00;
			t01_hold_reg <= 2'b00;
		end else if (at_s5) begin
			t01_hold_reg <= {TIMER1_ROLLOVER, TIMER0_ROLLOVER};
		end else if (mc_end) begin
			t01_pend_reg <= t01_hold_reg; // Polled next cycle
		end
	end

	////////////////////////////////////////////////////////////////////
	// Timer 2 flags: set beats software clear; hardware never clears overflow, but toggles the external flag in up/down mode
	wire trig_fall = trig_q_reg & ~TIMER2_TRIGGER_PIN;
	wire t2_updn   = t2_reg[IEPM_T2_UPDN];
	wire t2_quiet  = t2_reg[IEPM_T2_CLKOUT]; // Clock-out: rollovers silent
	wire ovf_set   = TIMER2_ROLLOVER & at_s2 & ~t2_quiet;
	wire ext_set   = trig_fall & t2_reg[IEPM_T2_TRIGEN] & ~t2_updn;
	wire ext_tog   = TIMER2_ROLLOVER & at_s2 & t2_updn;
	always_comb begin
		t2_next = t2_reg;
		if (wr_en & hit_t2)
			t2_next = PWDATA[7:0];
		if (ovf_set)
			t2_next[IEPM_T2_OVF] = 1'b1;
		if (ext_set)
			t2_next[IEPM_T2_EXT] = 1'b1;
		else if (ext_tog)
			t2_next[IEPM_T2_EXT] = ~t2_reg[IEPM_T2_EXT];
	end
	always_ff @(posedge CLK) begin
		if (SRST)
			trig_q_reg <= 1'b1;
		else
			trig_q_reg <= TIMER2_TRIGGER_PIN;
	end

	////////////////////////////////////////////////////////////////////
	// Interrupt enable mask; bit 6 is never stored
	always_comb begin
		ie_next = ie_reg;
		if (wr_en & hit_ie)
			ie_next = PWDATA[7:0] & IEPM_IE_IMPL;
	end
	always_ff @(posedge CLK) begin
		if (SRST) begin
			ie_reg    <= IEPM_IE_RESET;
			t2_reg    <= IEPM_T2_RESET;
			extpm_reg <= 1'b0;
		end else begin
			ie_reg <= ie_next; // Held through idle and power-down
			t2_reg <= t2_next;
			if (wr_en & hit_pw)
				extpm_reg <= PWDATA[IEPM_PWR_EXTPM];
		end
	end

	////////////////////////////////////////////////////////////////////
	// Source gathering and gating
	// In up/down mode the external flag is a count bit, not a request
	wire t2_req = t2_reg[IEPM_T2_OVF] |
		(t2_reg[IEPM_T2_EXT] & ~t2_updn);
	iepm_src_if src ();
	assign src.raw = {t2_req, SERIAL_IRQ,
		t01_pend_reg[1], ~OUTSIDE_IRQ_LINE1_N,
		t01_pend_reg[0], ~OUTSIDE_IRQ_LINE0_N};
	assign src.mask = ie_reg;
	iepm_gate u_gate (
		.s (src)
	);
	always_ff @(posedge CLK) begin
		if (SRST)
			irq_reg <= 6'h00;
		else
			irq_reg <= src.gated;
	end
	assign IRQ_REQ = irq_reg;

	////////////////////////////////////////////////////////////////////
	// Power mode machine
	wire go_idle = wr_en & hit_pw & PWDATA[IEPM_PWR_IDLE];
	wire go_down = wr_en & hit_pw & PWDATA[IEPM_PWR_DOWN];
	always_comb begin
		mode_next = mode_reg;
		unique case (mode_reg)
			IEPM_RUN: begin
				if (go_down)
					mode_next = IEPM_DOWN;
				else if (go_idle)
					mode_next = IEPM_IDLE;
			end
			IEPM_IDLE: begin
				if (src.any)
					mode_next = IEPM_RUN;
			end
			IEPM_DOWN: mode_next = IEPM_DOWN;
			default:   mode_next = IEPM_RUN;
		endcase
	end
	// Reset pin: idle exit opens a RAM-guard window of two machine cycles
	wire idle_rst = RESET_PIN & (mode_reg == IEPM_IDLE);
	always_ff @(posedge CLK) begin
		if (SRST) begin
			mode_reg <= IEPM_RUN; // Hardware reset leaves down
			rwin_reg <= 2'b00;
		end else begin
			mode_reg <= mode_next;
			if (idle_rst) begin
				mode_reg <= IEPM_RUN;
				rwin_reg <= 2'(IEPM_RST_WIN_MC);
			end else if (mc_end && rwin_reg != 2'b00)
				rwin_reg <= rwin_reg - 2'b01;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Pin states and core controls
	wire in_idle = mode_reg == IEPM_IDLE;
	wire in_down = mode_reg == IEPM_DOWN;
	assign CPU_RUN      = mode_reg == IEPM_RUN;
	assign OSC_RUN      = ~in_down;
	assign RAM_WR_BLOCK = rwin_reg != 2'b00; // Ports stay writable
	assign ADDR_LATCH_STROBE    = ~in_down;
	assign PROGRAM_STORE_STROBE = ~in_down;
	assign PORT0_FLOAT    = (in_idle | in_down) & extpm_reg;
	assign PORT2_ADDR_SEL = in_idle & extpm_reg;

	////////////////////////////////////////////////////////////////////
	// Read mux
	wire [7:0] stat = {2'b00, irq_reg};
	wire [7:0] pwr  = {5'h00, extpm_reg, in_down, in_idle};
	wire [7:0] rsel = hit_ie ? ie_reg : hit_pw ? pwr :
		hit_t2 ? t2_reg : hit_st ? stat : 8'h00;
	always_ff @(posedge CLK) begin
		if (SRST)
			PRDATA <= 32'h00000000;
		else if (PSEL & ~PENABLE & ~PWRITE)
			PRDATA <= {24'h000000, rsel};
	end

	////////////////////////////////////////////////////////////////////
	// Checks
	AST_GLOBAL_OFF: assert property (@(posedge CLK) disable iff (SRST)
		!ie_reg[IEPM_IE_GLOBAL] |=> IRQ_REQ == 6'h00)
		else $error("request passed with global enable low");
	AST_BIT6_ZERO: assert property (@(posedge CLK) disable iff (SRST)
		ie_reg[6] == 1'b0)
		else $error("reserved mask bit stored");
	AST_T2_OR: assert property (@(posedge CLK) disable iff (SRST)
		(ie_reg == 8'hA0 && t2_reg[IEPM_T2_OVF]) |=> IRQ_REQ[5])
		else $error("timer 2 overflow flag not requested");
	AST_T2_KEEP: assert property (@(posedge CLK) disable iff (SRST)
		(t2_reg[IEPM_T2_OVF] && !(wr_en && hit_t2)) |=> t2_reg[IEPM_T2_OVF])
		else $error("timer 2 flag cleared by hardware");
	AST_T2_SET: assert property (@(posedge CLK) disable iff (SRST)
		ovf_set |=> t2_reg[IEPM_T2_OVF])
		else $error("overflow flag lost against clear");
	AST_CLKOUT: assert property (@(posedge CLK) disable iff (SRST)
		(t2_quiet && !t2_reg[IEPM_T2_OVF] && !(wr_en && hit_t2))
		|=> !t2_reg[IEPM_T2_OVF])
		else $error("clock-out rollover flagged");
	AST_IDLE_EXIT: assert property (@(posedge CLK) disable iff (SRST)
		(in_idle && src.any) |=> CPU_RUN)
		else $error("idle did not end on enabled request");
	AST_DOWN_STAY: assert property (@(posedge CLK) disable iff (SRST)
		in_down |=> in_down && !OSC_RUN)
		else $error("power-down left without reset");
	AST_RAM_GUARD: assert property (@(posedge CLK) disable iff (SRST)
		idle_rst |=> RAM_WR_BLOCK && CPU_RUN)
		else $error("RAM not guarded after idle reset");
	AST_PINS_IDLE: assert property (@(posedge CLK) disable iff (SRST)
		in_idle |-> ADDR_LATCH_STROBE && PROGRAM_STORE_STROBE)
		else $error("strobes not high in idle");
	COV_IDLE: cover property (@(posedge CLK) in_idle ##1 CPU_RUN);
	COV_DOWN: cover property (@(posedge CLK) CPU_RUN ##1 in_down);
	COV_T2:   cover property (@(posedge CLK) IRQ_REQ[5]);
endmodule

/* iepm_cpu_model.sv */
module iepm_cpu_model
	import iepm_pkg::*;
(
	input  wire logic [5:0] irq_req,
	input  wire logic       cpu_run,
	output logic            vec_valid,
	output logic      [2:0] vec_num
);
	timeunit 1ns;
	timeprecision 1ps;

	////////////////////////////////////////////////////////////////////////
	// Core vectoring: six vectors, lowest pending index wins; no flag is
	// cleared here, so timer 2 stays pending until software clears it
	always_comb begin
		vec_valid = cpu_run && (|irq_req);
		vec_num   = 3'h0;
		for (int i = 5; i >= 0; i--) begin
			if (irq_req[i]) begin
				vec_num = 3'(i);
			end
		end
	end
endmodule

/* test_irq_enable_and_power_modes.sv */
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin error_cnt++; \
	$display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end

module test_irq_enable_and_power_modes
	import iepm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic CLK, SRST, PSEL, PENABLE, PWRITE, TRIG, RST_PIN;
	logic X0_N, X1_N, T0R, T1R, T2R, SER;
	logic [7:0]  PADDR;
	logic [31:0] PWDATA, PRDATA;
	logic PREADY, PSLVERR, CPU_RUN, OSC_RUN, RAM_BLK, ALE, PSTB, P0F, P2A;
	logic [5:0]  IRQ_REQ;
	logic        vec_valid;
	logic [2:0]  vec_num;
	int error_cnt, cmp_count, tcnt;

	iepm_top dut_u (.CLK(CLK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE),
		.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
		.PREADY(PREADY), .PSLVERR(PSLVERR), .OUTSIDE_IRQ_LINE0_N(X0_N),
		.OUTSIDE_IRQ_LINE1_N(X1_N), .TIMER0_ROLLOVER(T0R),
		.TIMER1_ROLLOVER(T1R), .TIMER2_ROLLOVER(T2R), .SERIAL_IRQ(SER),
		.TIMER2_TRIGGER_PIN(TRIG), .RESET_PIN(RST_PIN), .IRQ_REQ(IRQ_REQ),
		.CPU_RUN(CPU_RUN), .OSC_RUN(OSC_RUN), .RAM_WR_BLOCK(RAM_BLK),
		.ADDR_LATCH_STROBE(ALE), .PROGRAM_STORE_STROBE(PSTB),
		.PORT0_FLOAT(P0F), .PORT2_ADDR_SEL(P2A));
	iepm_cpu_model cpu_u (.irq_req(IRQ_REQ), .cpu_run(CPU_RUN),
		.vec_valid(vec_valid), .vec_num(vec_num));

	////////////////////////////////////////////////////////////////////////
	// Clock and a hang guard well above the expected run length
	always #4 CLK = ~CLK;
	always @(posedge CLK) begin
		tcnt++;
		if (tcnt == 4000) begin
			error_cnt++;
			summarize();
		end
	end

	task summarize;
		$display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task cyc(input int n);
		repeat (n) @(posedge CLK);
	endtask

	////////////////////////////////////////////////////////////////////////
	// APB transfer: request held until pready is seen high at an edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge CLK);
		PSEL <= 1'b1; PENABLE <= 1'b0; PWRITE <= w; PADDR <= a; PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		do @(posedge CLK); while (PREADY !== 1'b1);
		r = PRDATA;
		e = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask

	task rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h00000000, r, e);
		`CHK(r, x)
		`CHK(e, xe)
	endtask

	// Sources in request order {t2,ser,t1,x1,t0,x0}; outside lines are low
	task src(input logic [5:0] v);
		@(posedge CLK);
		X0_N <= ~v[0]; T0R <= v[1]; X1_N <= ~v[2];
		T1R <= v[3]; SER <= v[4]; T2R <= v[5];
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		CLK = 0; SRST = 1; PSEL = 0; PENABLE = 0; PWRITE = 0; PADDR = 8'h00;
		PWDATA = 32'h00000000; TRIG = 1; RST_PIN = 0;
		X0_N = 1; X1_N = 1; T0R = 0; T1R = 0; T2R = 0; SER = 0;
		cyc(2);
		SRST <= 1'b0;
		rd(IEPM_OFS_IE, 32'h00000000, 1'b0);
		wr(IEPM_OFS_IE, 32'h000000BF); // Bit 6 left zero
		rd(IEPM_OFS_IE, 32'h000000BF, 1'b0);
		rd(8'h10, 32'h00000000, 1'b1);
		// Every source active; each mask bit alone must pass only its own
		src(6'h3F);
		wr(IEPM_OFS_IE, 32'h0000003F);
		cyc(30);
		`CHK(IRQ_REQ, 6'h00)
		for (int i = 0; i < 6; i++) begin
			wr(IEPM_OFS_IE, 32'h00000080 | (32'h00000001 << i));
			cyc(2);
			`CHK(IRQ_REQ, 6'h01 << i)
			`CHK(vec_num, 3'(i))
		end
		// Timer 2 flag outlives its source until software clears it
		src(6'h00);
		wr(IEPM_OFS_IE, 32'h000000BF);
		cyc(30);
		`CHK(IRQ_REQ, 6'h20)
		rd(IEPM_OFS_T2CTL, 32'h00000080, 1'b0);
		rd(IEPM_OFS_STAT, 32'h00000020, 1'b0);
		wr(IEPM_OFS_T2CTL, 32'h00000001);
		src(6'h20);
		cyc(30);
		src(6'h00);
		cyc(2);
		`CHK(IRQ_REQ, 6'h00)
		wr(IEPM_OFS_T2CTL, 32'h00000008);
		TRIG <= 1'b0;
		cyc(3);
		rd(IEPM_OFS_T2CTL, 32'h00000048, 1'b0);
		`CHK(IRQ_REQ, 6'h20)
		TRIG <= 1'b1;
		wr(IEPM_OFS_T2CTL, 32'h00000000);
		// Idle left by an enabled request
		wr(IEPM_OFS_IE, 32'h00000081);
		wr(IEPM_OFS_PWR, 32'h00000001); // No port write follows
		cyc(1);
		`CHK({CPU_RUN, OSC_RUN, ALE, PSTB, P0F}, 5'h0E)
		src(6'h01);
		cyc(3);
		`CHK(CPU_RUN, 1'b1)
		src(6'h00);
		// Idle with external memory, left by the reset pin
		wr(IEPM_OFS_PWR, 32'h00000005);
		cyc(1);
		`CHK({CPU_RUN, ALE, PSTB, P0F, P2A}, 5'h0F)
		RST_PIN <= 1'b1;
		cyc(2);
		RST_PIN <= 1'b0;
		`CHK({CPU_RUN, RAM_BLK}, 2'h3)
		cyc(26);
		`CHK(RAM_BLK, 1'b0)
		// Power-down ignores requests and the pin; only SRST ends it
		wr(IEPM_OFS_PWR, 32'h00000006);
		cyc(1);
		`CHK({CPU_RUN, OSC_RUN, ALE, PSTB, P0F, P2A}, 6'h02)
		`CHK(OSC_RUN, 1'b0)
		src(6'h01);
		RST_PIN <= 1'b1;
		cyc(5);
		`CHK(OSC_RUN, 1'b0)
		SRST <= 1'b1; // Held for oscillator restart
		RST_PIN <= 1'b0;
		cyc(2);
		SRST <= 1'b0;
		src(6'h00);
		`CHK({CPU_RUN, OSC_RUN}, 2'h3)
		rd(IEPM_OFS_IE, 32'h00000000, 1'b0);
		summarize();
	end
endmodule
